// *** logic/mailbox_bus_matching_consts.vh ***
// constants shared by the mailbox and bus-matching block
// assumes inclusion by bare name from the design files
`ifndef MAILBOX_BUS_MATCHING_CONSTS_VH
`define MAILBOX_BUS_MATCHING_CONSTS_VH

// apb register byte addresses
`define ADDR_CONFIG 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_A_TO_B_MAIL 8'h08
`define ADDR_B_TO_A_MAIL 8'h0c

// config register fields and reset value
`define CFG_WIDTH_MATCH_BIT 0
`define CFG_SIZE_BIT 1
`define CFG_ENDIAN_BIT 2
`define CFG_RESET 3'h0

// status register fields
`define ST_A_TO_B_FLAG_BIT 0
`define ST_B_TO_A_FLAG_BIT 1
`define ST_B_READY_BIT 2
`define ST_A_READY_BIT 3
`define ST_RUN_BIT 4
`define ST_MODE_LSB 5
`define ST_BIG_BIT 7

// port b size encodings
`define MODE_LONG 2'h0
`define MODE_WORD 2'h1
`define MODE_BYTE 2'h2

// lane masks per size
`define MASK_LONG 36'hfffffffff
`define MASK_WORD 36'h00003ffff
`define MASK_BYTE 36'h0000001ff

// part positions inside a long word
`define SHIFT_WORD_HIGH 6'h12
`define SHIFT_BYTE_HIGH 6'h1b

// pin synchroniser vector width: clock, four controls, 36 data
`define PIN_VEC_WIDTH 41

`endif

// *** logic/sync_queue.v ***
// long-word queue with honest full and empty, cleared on master reset
// assumes push and pop come from logic on the same clock
`default_nettype none
module sync_queue #(
	parameter WIDTH = 36,
	parameter DEPTH_LOG = 4
) (
	input wire clk,
	input wire rst_n,
	input wire clear,
	input wire push,
	input wire [WIDTH-1:0] push_data,
	input wire pop,
	output wire [WIDTH-1:0] pop_data,
	output wire empty,
	output wire full
);
	localparam DEPTH = 1 << DEPTH_LOG;
	reg [WIDTH-1:0] store [0:DEPTH-1];
	reg [DEPTH_LOG:0] wr_ptr_reg;
	reg [DEPTH_LOG:0] rd_ptr_reg;
	wire do_push;
	wire do_pop;

	assign empty = (wr_ptr_reg == rd_ptr_reg);
	assign full = (wr_ptr_reg[DEPTH_LOG] != rd_ptr_reg[DEPTH_LOG]) &&
		(wr_ptr_reg[DEPTH_LOG-1:0] == rd_ptr_reg[DEPTH_LOG-1:0]);
	assign do_push = push && !full && !clear;
	assign do_pop = pop && !empty && !clear;
	assign pop_data = store[rd_ptr_reg[DEPTH_LOG-1:0]];

	always @(posedge clk) begin
		if (do_push) begin
			store[wr_ptr_reg[DEPTH_LOG-1:0]] <= push_data;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_reg <= {(DEPTH_LOG+1){1'b0}};
			rd_ptr_reg <= {(DEPTH_LOG+1){1'b0}};
		end else if (clear) begin
			wr_ptr_reg <= {(DEPTH_LOG+1){1'b0}};
			rd_ptr_reg <= {(DEPTH_LOG+1){1'b0}};
		end else begin
			if (do_push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (do_pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// *** logic/mailbox_bus_matching.v ***
// mailbox bypass registers and port b bus matching of a two-way queue
// assumes port clocks well below pclk/3; all port pins are synchronised
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`include "mailbox_bus_matching_consts.vh"
`default_nettype none

// Summary of operation
// RL1: one 36-bit mail register each direction
// RL2: mail select steers transfer to mail
// RL3: port a mail write, lanes per size
// RL4: port b mail write, lanes per size
// RL5: mail write drives its flag low
// RL6: writes ignored while mail flag low
// RL7: outputs from queue or mail by select
// RL8: port b mail read sets flag high
// RL9: port a mail read sets flag high
// RL10: reading mail leaves contents intact
// RL11: mail skips endian and width packing
// RL12: port b size applied at reset end
// RL13: endian captured at master reset release
// RL14: parts sequenced big or little endian
// RL15: queues hold only whole long words
// RL16: long word unpacked via auxiliary register
// RL17: unused port b read lanes undefined
// RL18: last part stores packed long word
// RL19: unused port b write lanes ignored
// RL20: output ready falls after last part
// RL21: match low long, size picks word/byte
// RL22: big endian sends high part first
module mailbox_bus_matching #(
	parameter QUEUE_DEPTH_LOG = 4
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire port_a_clock,
	input wire port_a_select_n,
	input wire port_a_write_not_read,
	input wire port_a_enable,
	input wire port_a_mail_select,
	input wire [35:0] port_a_data_in,
	output wire [35:0] port_a_data_out,
	output wire port_a_data_oe,
	input wire port_b_clock,
	input wire port_b_select_n,
	input wire port_b_read_not_write,
	input wire port_b_enable,
	input wire port_b_mail_select,
	input wire [35:0] port_b_data_in,
	output wire [35:0] port_b_data_out,
	output wire port_b_data_oe,
	input wire master_reset_one_n,
	input wire master_reset_two_n,
	output wire a_to_b_mail_flag_n,
	output wire b_to_a_mail_flag_n,
	output wire port_b_output_ready,
	output wire port_a_output_ready,
	output wire port_a_input_ready,
	output wire port_b_input_ready
);
	// size from match and size bits
	function [1:0] mode_of;
		input wm;
		input sz;
		begin
			mode_of = wm ? (sz ? `MODE_BYTE : `MODE_WORD) : `MODE_LONG;
		end
	endfunction

	function [35:0] lane_mask;
		input [1:0] mode;
		begin
			case (mode)
				`MODE_WORD: lane_mask = `MASK_WORD;
				`MODE_BYTE: lane_mask = `MASK_BYTE;
				default: lane_mask = `MASK_LONG;
			endcase
		end
	endfunction

	// bit position of part idx inside the long word
	function [5:0] part_shift;
		input [1:0] mode;
		input [1:0] idx;
		input big;
		reg [5:0] nine_idx;
		begin
			nine_idx = {1'b0, idx, 3'h0} + {4'h0, idx};
			case (mode)
				`MODE_WORD: part_shift = (idx[0] ^ big) ? `SHIFT_WORD_HIGH : 6'h00;
				`MODE_BYTE: part_shift = big ? (`SHIFT_BYTE_HIGH - nine_idx) : nine_idx;
				default: part_shift = 6'h00;
			endcase
		end
	endfunction

	function part_last;
		input [1:0] mode;
		input [1:0] idx;
		begin
			case (mode)
				`MODE_WORD: part_last = idx[0];
				`MODE_BYTE: part_last = (idx == 2'h3);
				default: part_last = 1'b1;
			endcase
		end
	endfunction

	function [35:0] part_extract;
		input [35:0] word;
		input [1:0] mode;
		input [1:0] idx;
		input big;
		begin
			part_extract = (word >> part_shift(mode, idx, big)) & lane_mask(mode);
		end
	endfunction

	function [35:0] part_insert;
		input [35:0] word;
		input [35:0] part;
		input [1:0] mode;
		input [1:0] idx;
		input big;
		reg [35:0] m;
		begin
			m = lane_mask(mode) << part_shift(mode, idx, big);
			part_insert = (word & ~m) | ((part & lane_mask(mode)) << part_shift(mode, idx, big));
		end
	endfunction

	// pin synchronisers, third stage aligns data with the clock edge
	reg [`PIN_VEC_WIDTH-1:0] a_s1_reg, a_s2_reg, a_s3_reg;
	reg [`PIN_VEC_WIDTH-1:0] b_s1_reg, b_s2_reg, b_s3_reg;
	reg [1:0] mr_s1_reg, mr_s2_reg;
	wire [`PIN_VEC_WIDTH-1:0] a_pins;
	wire [`PIN_VEC_WIDTH-1:0] b_pins;
	assign a_pins = {port_a_clock, port_a_select_n, port_a_write_not_read,
		port_a_enable, port_a_mail_select, port_a_data_in};
	assign b_pins = {port_b_clock, port_b_select_n, port_b_read_not_write,
		port_b_enable, port_b_mail_select, port_b_data_in};

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			a_s1_reg <= {`PIN_VEC_WIDTH{1'b0}};
			a_s2_reg <= {`PIN_VEC_WIDTH{1'b0}};
			a_s3_reg <= {`PIN_VEC_WIDTH{1'b0}};
			b_s1_reg <= {`PIN_VEC_WIDTH{1'b0}};
			b_s2_reg <= {`PIN_VEC_WIDTH{1'b0}};
			b_s3_reg <= {`PIN_VEC_WIDTH{1'b0}};
			mr_s1_reg <= 2'h0;
			mr_s2_reg <= 2'h0;
		end else begin
			a_s1_reg <= a_pins;
			a_s2_reg <= a_s1_reg;
			a_s3_reg <= a_s2_reg;
			b_s1_reg <= b_pins;
			b_s2_reg <= b_s1_reg;
			b_s3_reg <= b_s2_reg;
			mr_s1_reg <= {master_reset_two_n, master_reset_one_n};
			mr_s2_reg <= mr_s1_reg;
		end
	end

	wire a_edge = a_s2_reg[40] & ~a_s3_reg[40];
	wire a_sel = ~a_s3_reg[39];
	wire a_wr = a_s3_reg[38];
	wire a_en = a_s3_reg[37];
	wire a_mail = a_s3_reg[36];
	wire [35:0] a_din = a_s3_reg[35:0];
	wire b_edge = b_s2_reg[40] & ~b_s3_reg[40];
	wire b_sel = ~b_s3_reg[39];
	wire b_rd = b_s3_reg[38];
	wire b_en = b_s3_reg[37];
	wire b_mail = b_s3_reg[36];
	wire [35:0] b_din = b_s3_reg[35:0];

	// master reset and configuration capture
	reg run_reg;
	reg [2:0] config_reg;
	reg [1:0] mode_reg;
	reg big_reg;
	wire mr_released = &mr_s2_reg;
	wire in_reset = ~run_reg;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_reg <= 1'b0;
			mode_reg <= `MODE_LONG;
			big_reg <= 1'b0;
		end else begin
			run_reg <= mr_released;
			if (mr_released && !run_reg) begin
				// RL12: size applied as reset ends
				// RL21: match and size decode
				mode_reg <= mode_of(config_reg[`CFG_WIDTH_MATCH_BIT],
					config_reg[`CFG_SIZE_BIT]);
				// RL13: endian latched on release
				big_reg <= config_reg[`CFG_ENDIAN_BIT];
			end
		end
	end

	// RL2: mail select splits transfers
	wire a_go = a_edge & a_sel & a_en & run_reg;
	wire b_go = b_edge & b_sel & b_en & run_reg;
	wire a_mail_wr = a_go & a_wr & a_mail;
	wire a_mail_rd = a_go & ~a_wr & a_mail;
	wire a_q_wr = a_go & a_wr & ~a_mail;
	wire a_q_rd = a_go & ~a_wr & ~a_mail;
	wire b_mail_wr = b_go & ~b_rd & b_mail;
	wire b_mail_rd = b_go & b_rd & b_mail;
	wire b_q_wr = b_go & ~b_rd & ~b_mail;
	wire b_q_rd = b_go & b_rd & ~b_mail;
	wire [35:0] mask = lane_mask(mode_reg);

	// mailbox registers and flags
	reg [35:0] a_to_b_mail_register;
	reg [35:0] b_to_a_mail_register;
	reg a_to_b_flag_reg;
	reg b_to_a_flag_reg;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			a_to_b_mail_register <= 36'h000000000;
			b_to_a_mail_register <= 36'h000000000;
			a_to_b_flag_reg <= 1'b1;
			b_to_a_flag_reg <= 1'b1;
		end else if (in_reset) begin
			a_to_b_flag_reg <= 1'b1;
			b_to_a_flag_reg <= 1'b1;
		end else begin
			// RL1: bypass register a to b
			// RL6: only while flag high
			if (a_mail_wr && a_to_b_flag_reg) begin
				// RL3: masked port a lanes
				// RL11: no reordering for mail
				a_to_b_mail_register <= a_din & mask;
				// RL5: flag low on write
				a_to_b_flag_reg <= 1'b0;
			end else if (b_mail_rd) begin
				// RL8: port b read empties box
				a_to_b_flag_reg <= 1'b1;
			end
			// RL6: blocked while unread
			if (b_mail_wr && b_to_a_flag_reg) begin
				// RL4: masked port b lanes
				b_to_a_mail_register <= b_din & mask;
				// RL5: flag low on write
				b_to_a_flag_reg <= 1'b0;
			end else if (a_mail_rd) begin
				// RL9: port a read empties box
				b_to_a_flag_reg <= 1'b1;
			end
		end
	end

	// queues of long words
	wire a2b_empty, a2b_full, b2a_empty, b2a_full;
	wire [35:0] a2b_pop_data, b2a_pop_data;
	reg [35:0] pack_acc_reg;
	reg [1:0] pack_cnt_reg;
	reg [35:0] unpack_aux_reg;
	reg [1:0] unpack_cnt_reg;
	reg unpack_hold_reg;
	// RL19: upper lanes dropped by insert mask
	wire [35:0] pack_word = part_insert(pack_acc_reg, b_din, mode_reg,
		pack_cnt_reg, big_reg);
	wire b_part_wr = b_q_wr & ~b2a_full;
	// RL18: last part pushes whole word
	wire b2a_push = b_part_wr & part_last(mode_reg, pack_cnt_reg);
	wire a2b_pop = b_q_rd & ~unpack_hold_reg & ~a2b_empty;

	// RL15: only long words enter memory
	sync_queue #(.WIDTH(36), .DEPTH_LOG(QUEUE_DEPTH_LOG)) a_to_b_queue (
		.clk(pclk),
		.rst_n(presetn),
		.clear(in_reset),
		.push(a_q_wr),
		.push_data(a_din),
		.pop(a2b_pop),
		.pop_data(a2b_pop_data),
		.empty(a2b_empty),
		.full(a2b_full)
	);

	sync_queue #(.WIDTH(36), .DEPTH_LOG(QUEUE_DEPTH_LOG)) b_to_a_queue (
		.clk(pclk),
		.rst_n(presetn),
		.clear(in_reset),
		.push(b2a_push),
		.push_data(pack_word),
		.pop(a_q_rd),
		.pop_data(b2a_pop_data),
		.empty(b2a_empty),
		.full(b2a_full)
	);

	// port b packing and unpacking
	reg [35:0] b_fifo_out_reg;
	reg [35:0] a_fifo_out_reg;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pack_acc_reg <= 36'h000000000;
			pack_cnt_reg <= 2'h0;
			unpack_aux_reg <= 36'h000000000;
			unpack_cnt_reg <= 2'h0;
			unpack_hold_reg <= 1'b0;
			b_fifo_out_reg <= 36'h000000000;
			a_fifo_out_reg <= 36'h000000000;
		end else if (in_reset) begin
			pack_cnt_reg <= 2'h0;
			unpack_cnt_reg <= 2'h0;
			unpack_hold_reg <= 1'b0;
		end else begin
			// RL14: parts in captured order
			if (b_part_wr) begin
				pack_acc_reg <= pack_word;
				pack_cnt_reg <= part_last(mode_reg, pack_cnt_reg) ?
					2'h0 : pack_cnt_reg + 2'h1;
			end
			// RL16: first part out, rest held
			if (a2b_pop) begin
				unpack_aux_reg <= a2b_pop_data;
				// RL22: first part per endian
				// RL17: lanes above size read zero
				b_fifo_out_reg <= part_extract(a2b_pop_data, mode_reg, 2'h0, big_reg);
				unpack_hold_reg <= ~part_last(mode_reg, 2'h0);
				unpack_cnt_reg <= 2'h1;
			end else if (b_q_rd && unpack_hold_reg) begin
				b_fifo_out_reg <= part_extract(unpack_aux_reg, mode_reg,
					unpack_cnt_reg, big_reg);
				unpack_hold_reg <= ~part_last(mode_reg, unpack_cnt_reg);
				unpack_cnt_reg <= unpack_cnt_reg + 2'h1;
			end
			if (a_q_rd && !b2a_empty) begin
				a_fifo_out_reg <= b2a_pop_data;
			end
		end
	end

	// data pin drivers
	reg [35:0] a_dout_reg, b_dout_reg;
	reg a_oe_reg, b_oe_reg;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			a_dout_reg <= 36'h000000000;
			b_dout_reg <= 36'h000000000;
			a_oe_reg <= 1'b0;
			b_oe_reg <= 1'b0;
		end else begin
			// RL7: queue or mailbox source
			// RL10: reads never touch mail contents
			a_dout_reg <= a_mail ? (b_to_a_mail_register & mask) : a_fifo_out_reg;
			b_dout_reg <= b_mail ? (a_to_b_mail_register & mask) : b_fifo_out_reg;
			a_oe_reg <= a_sel & ~a_wr & run_reg;
			b_oe_reg <= b_sel & b_rd & run_reg;
		end
	end

	assign port_a_data_out = a_dout_reg;
	assign port_b_data_out = b_dout_reg;
	assign port_a_data_oe = a_oe_reg;
	assign port_b_data_oe = b_oe_reg;
	assign a_to_b_mail_flag_n = a_to_b_flag_reg;
	assign b_to_a_mail_flag_n = b_to_a_flag_reg;
	// RL20: ready held until last part read
	assign port_b_output_ready = run_reg & (unpack_hold_reg | ~a2b_empty);
	assign port_a_output_ready = run_reg & ~b2a_empty;
	assign port_a_input_ready = run_reg & ~a2b_full;
	assign port_b_input_ready = run_reg & ~b2a_full;

	// apb slave, zero wait states
	reg [31:0] prdata_reg;
	reg err_reg;
	wire setup = psel & ~penable;
	wire access = psel & penable;
	wire hit_cfg = (paddr == `ADDR_CONFIG);
	wire hit_ro = (paddr == `ADDR_STATUS) | (paddr == `ADDR_A_TO_B_MAIL) |
		(paddr == `ADDR_B_TO_A_MAIL);
	reg [31:0] read_mux;

	always @* begin
		read_mux = 32'h00000000;
		case (paddr)
			`ADDR_CONFIG: read_mux = {29'h00000000, config_reg};
			`ADDR_STATUS: read_mux = {24'h000000, big_reg, mode_reg, run_reg,
				port_a_output_ready, port_b_output_ready,
				b_to_a_flag_reg, a_to_b_flag_reg};
			`ADDR_A_TO_B_MAIL: read_mux = a_to_b_mail_register[31:0];
			`ADDR_B_TO_A_MAIL: read_mux = b_to_a_mail_register[31:0];
			default: read_mux = 32'h00000000;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h00000000;
			err_reg <= 1'b0;
			config_reg <= `CFG_RESET;
		end else begin
			if (setup) begin
				prdata_reg <= pwrite ? 32'h00000000 : read_mux;
				err_reg <= ~(hit_cfg | (hit_ro & ~pwrite));
			end
			if (access && pwrite && hit_cfg) begin
				config_reg <= pwdata[2:0];
			end
		end
	end

	assign prdata = prdata_reg;
	assign pready = 1'b1;
	assign pslverr = access & err_reg;
endmodule
`default_nettype wire

// *** dv/mailbox_bus_matching_assertions.sv ***
// apb answers, master reset effects and causes of the mail flag changes
// assumes binding to the block top; sees its ports only
`default_nettype none
module mailbox_bus_matching_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic port_a_select_n,
	input wire logic port_a_write_not_read,
	input wire logic port_a_enable,
	input wire logic port_a_mail_select,
	input wire logic port_b_select_n,
	input wire logic port_b_read_not_write,
	input wire logic port_b_enable,
	input wire logic port_b_mail_select,
	input wire logic port_a_data_oe,
	input wire logic port_b_data_oe,
	input wire logic master_reset_one_n,
	input wire logic master_reset_two_n,
	input wire logic a_to_b_mail_flag_n,
	input wire logic b_to_a_mail_flag_n,
	input wire logic port_a_input_ready,
	input wire logic port_b_input_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic acc = psel && penable;
	wire logic mapped = paddr[7:4] == 4'h0 && paddr[1:0] == 2'h0;
	wire logic a_sel = !port_a_select_n && port_a_enable && port_a_mail_select;
	wire logic b_sel = !port_b_select_n && port_b_enable && port_b_mail_select;
	wire logic mr_n = master_reset_one_n && master_reset_two_n;
	sequence master_reset_held;
		!mr_n [*6];
	endsequence
	a_zero_wait: assert property (acc |-> pready)
		else $error("access phase without ready");
	a_unmapped_error: assert property (acc && !mapped |-> pslverr)
		else $error("unmapped access not refused");
	a_readonly_error: assert property (acc && pwrite && paddr != 8'h00 |-> pslverr)
		else $error("read-only write not refused");
	a_config_clean: assert property (acc && paddr == 8'h00 |-> !pslverr)
		else $error("config access refused");
	a_prdata_hold: assert property (!$stable(prdata) |-> $past(psel && !penable))
		else $error("read data changed outside setup");
	a_reset_flags: assert property (master_reset_held |-> a_to_b_mail_flag_n && b_to_a_mail_flag_n)
		else $error("mail flags low in master reset");
	a_reset_quiet: assert property (master_reset_held |->
		!port_a_input_ready && !port_b_input_ready && !port_a_data_oe && !port_b_data_oe)
		else $error("port active in master reset");
	a_ab_flag_set: assert property (
		$fell(a_to_b_mail_flag_n) |-> $past(a_sel && port_a_write_not_read))
		else $error("a to b flag fell without mail write");
	a_ab_flag_clear: assert property (
		$rose(a_to_b_mail_flag_n) |-> $past(b_sel && port_b_read_not_write) || !$past(mr_n))
		else $error("a to b flag rose without mail read");
	a_ba_flag_set: assert property (
		$fell(b_to_a_mail_flag_n) |-> $past(b_sel && !port_b_read_not_write))
		else $error("b to a flag fell without mail write");
	a_ba_flag_clear: assert property (
		$rose(b_to_a_mail_flag_n) |-> $past(a_sel && !port_a_write_not_read) || !$past(mr_n))
		else $error("b to a flag rose without mail read");
endmodule
bind mailbox_bus_matching mailbox_bus_matching_checker chk (.*);
`default_nettype wire

// *** dv/port_host.sv ***
// host model for one port: one transfer per port clock pulse
// assumes pclk at least four times the port clock it makes
`default_nettype none
module port_host #(
	parameter bit WRITE_LEVEL = 1'b1
) (
	input wire logic pclk,
	output logic clk_pin,
	output logic sel_n,
	output logic dir,
	output logic en,
	output logic mail,
	output logic [35:0] data,
	input wire logic [35:0] rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		clk_pin = 1'b0;
		sel_n = 1'b1;
		dir = 1'b0;
		en = 1'b0;
		mail = 1'b0;
		data = 36'h0;
	end
	// pins held well around the rise; released data shows its inverse
	task automatic xfer(input logic wr, input logic mb, input logic [35:0] d,
			output logic [35:0] q);
		@(posedge pclk);
		sel_n <= 1'b0;
		en <= 1'b1;
		dir <= wr ~^ WRITE_LEVEL;
		mail <= mb;
		data <= d;
		repeat (3) @(posedge pclk);
		clk_pin <= 1'b1;
		repeat (6) @(posedge pclk);
		@(negedge pclk);
		q = rdata;
		@(posedge pclk);
		clk_pin <= 1'b0;
		repeat (4) @(posedge pclk);
		sel_n <= 1'b1;
		en <= 1'b0;
		data <= ~d;
	endtask
endmodule
`default_nettype wire

// *** dv/mailbox_bus_matching_test.sv ***
// mail and queue traffic through every port b size and order
// assumes the design header on the include path
`include "mailbox_bus_matching_consts.vh"
`default_nettype none
module mailbox_bus_matching_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, mr_n = 1'b0, err, big;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, rd;
	logic [35:0] q, mask;
	logic [35:0] lw = 36'h9_1234_5678;
	logic [2:0] cfg [5] = '{3'b000, 3'b101, 3'b011, 3'b001, 3'b111};
	wire logic [31:0] prdata;
	wire logic pready, pslverr, ack, bck, asn, bsn, adir, bdir, aen, ben, amb, bmb;
	wire logic af, bf, bor, aor, air, bir, aoe, boe;
	wire logic [35:0] ai, ao, bi, bo;
	int bad_count = 0;
	int tests_run = 0;
	int n;
	always #12.5 pclk = ~pclk;
	mailbox_bus_matching dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .port_a_clock(ack), .port_a_select_n(asn),
		.port_a_write_not_read(adir), .port_a_enable(aen), .port_a_mail_select(amb),
		.port_a_data_in(ai), .port_a_data_out(ao), .port_a_data_oe(aoe), .port_b_clock(bck),
		.port_b_select_n(bsn), .port_b_read_not_write(bdir), .port_b_enable(ben),
		.port_b_mail_select(bmb), .port_b_data_in(bi), .port_b_data_out(bo),
		.port_b_data_oe(boe), .master_reset_one_n(mr_n), .master_reset_two_n(mr_n),
		.a_to_b_mail_flag_n(af), .b_to_a_mail_flag_n(bf), .port_b_output_ready(bor),
		.port_a_output_ready(aor), .port_a_input_ready(air), .port_b_input_ready(bir));
	port_host #(.WRITE_LEVEL(1'b1)) ha (.pclk(pclk), .clk_pin(ack), .sel_n(asn), .dir(adir),
		.en(aen), .mail(amb), .data(ai), .rdata(ao));
	port_host #(.WRITE_LEVEL(1'b0)) hb (.pclk(pclk), .clk_pin(bck), .sel_n(bsn), .dir(bdir),
		.en(ben), .mail(bmb), .data(bi), .rdata(bo));
	task automatic chk(input string name, input logic [35:0] seen, input logic [35:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// part i of a long word in transfer order
	function automatic logic [35:0] part(input logic [35:0] w, input int c, input int i,
			input logic be);
		int wd;
		wd = 36 / c;
		return (w >> (be ? (c - 1 - i) * wd : i * wd)) & ((36'h1 << wd) - 36'h1);
	endfunction
	task automatic final_report;
		if (bad_count == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge pclk);
		bad_count++;
		final_report;
	end
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 8'h10, 32'h0, rd, err);
		chk("unmapped", 36'(err), 36'h1);
		apb(1'b1, `ADDR_STATUS, 32'hff, rd, err);
		chk("ro write", 36'(err), 36'h1);
		foreach (cfg[k]) begin
			n = cfg[k][0] ? (cfg[k][1] ? 4 : 2) : 1;
			big = cfg[k][2];
			mask = part(`MASK_LONG, n, 0, 1'b0);
			mr_n <= 1'b0;
			apb(1'b1, `ADDR_CONFIG, {29'h0, cfg[k]}, rd, err);
			apb(1'b0, `ADDR_CONFIG, 32'h0, rd, err);
			chk("config", 36'(rd), 36'(cfg[k]));
			mr_n <= 1'b1;
			repeat (6) @(posedge pclk);
			apb(1'b0, `ADDR_STATUS, 32'h0, rd, err);
			chk("status", 36'(rd[6:4]), 36'({2'(n / 2), 1'b1}));
			chk("a in ready", 36'(air), 36'h1);
			chk("b in ready", 36'(bir), 36'h1);
			ha.xfer(1'b1, 1'b1, 36'h9_8765_4321, q);
			chk("a2b flag", 36'(af), 36'h0);
			chk("a oe", 36'(aoe), 36'h0);
			ha.xfer(1'b1, 1'b1, 36'h1_1111_1111, q);
			apb(1'b0, `ADDR_A_TO_B_MAIL, 32'h0, rd, err);
			chk("a2b apb", 36'(rd), 36'h8765_4321 & mask);
			repeat (2) begin
				hb.xfer(1'b0, 1'b1, 36'h0, q);
				chk("a2b mail", q, 36'h9_8765_4321 & mask);
				chk("b oe", 36'(boe), 36'h1);
			end
			chk("a2b flag", 36'(af), 36'h1);
			hb.xfer(1'b1, 1'b1, 36'hf_ffff_ffff, q);
			chk("b2a flag", 36'(bf), 36'h0);
			chk("b oe", 36'(boe), 36'h0);
			ha.xfer(1'b0, 1'b1, 36'h0, q);
			chk("b2a mail", q, mask);
			chk("b2a flag", 36'(bf), 36'h1);
			chk("a oe", 36'(aoe), 36'h1);
			ha.xfer(1'b1, 1'b0, lw, q);
			for (int i = 0; i < n; i++) begin
				chk("b ready", 36'(bor), 36'h1);
				hb.xfer(1'b0, 1'b0, 36'h0, q);
				chk("b part", q, part(lw, n, i, big));
			end
			chk("b ready", 36'(bor), 36'h0);
			for (int i = 0; i < n; i++) begin
				chk("a ready", 36'(aor), 36'h0);
				hb.xfer(1'b1, 1'b0, part(lw, n, i, big) | ~mask, q);
			end
			chk("a ready", 36'(aor), 36'h1);
			ha.xfer(1'b0, 1'b0, 36'h0, q);
			chk("a long", q, lw);
		end
		final_report;
	end
endmodule
`default_nettype wire
